// >>> halfbridge_cfg_defines.svh
`ifndef HALFBRIDGE_CFG_DEFINES_SVH
`define HALFBRIDGE_CFG_DEFINES_SVH

// Register offsets (serial address field)
`define ADDR_FAULT_STAT 4'h0
`define ADDR_FET_STAT 4'h1
`define ADDR_MAIN_CTRL 4'h2
`define ADDR_GATE_WDOG 4'h3
`define ADDR_OC_MONITOR 4'h4
`define ADDR_CHOP_CFG 4'h5

// Reset values
`define MAIN_CTRL_RST 8'h18
`define GATE_WDOG_RST 8'h07
`define OC_MONITOR_RST 8'h70
`define CHOP_CFG_RST 8'h01

// Writable bits of the monitor register, bits 3-2 reserved
`define OC_MONITOR_WMASK 8'hF3

// Lock field, fault clear bit and input bits of the main control register
`define LOCK_LSB 3
`define LOCK_MSB 5
`define LOCK_KEY_SET 3'h6
`define LOCK_KEY_CLEAR 3'h3
`define CLR_FAULT_BIT 0
`define IN1_BIT 2
`define IN2_BIT 1

// Serial frame layout, 16 bits, MSB first
`define FRAME_BITS 5'h10
`define FRAME_RD_BIT 15
`define FRAME_ADDR_MSB 14
`define FRAME_ADDR_LSB 11
`define FRAME_DATA_BITS 5'h08
`define FRAME_ADDR_DONE 5'h04

// Watchdog timeouts in ms, clock rate in MHz
`define SYS_CLK_MHZ 100
`define WD_TIME0_MS 10
`define WD_TIME1_MS 20
`define WD_TIME2_MS 50
`define WD_TIME3_MS 100

`endif

// >>> halfbridge_cfg_pkg.sv
`default_nettype none
package halfbridge_cfg_pkg;

    // Drive strength, dead time and watchdog controls
    typedef struct packed {
        logic [1:0] deadtime_sel;
        logic wdog_enable;
        logic [1:0] wdog_timeout_sel;
        logic [2:0] gate_current_sel;
    } gate_wdog_s;

    // Overcurrent monitor controls
    typedef struct packed {
        logic sense_out_clamp;
        logic [2:0] drain_source_threshold;
        logic [1:0] reserved;
        logic high_fet_monitor_off;
        logic low_fet_monitor_off;
    } oc_monitor_s;

    // Current chopping and shunt amplifier controls
    typedef struct packed {
        logic [1:0] chop_off_time;
        logic regulation_disable;
        logic [1:0] ref_scale_sel;
        logic sample_hold_on;
        logic [1:0] amp_gain_sel;
    } chop_cfg_s;

    // Whole state of the register bank
    typedef struct packed {
        logic sck_m;
        logic sck_q;
        logic sck_d;
        logic cs_m;
        logic cs_q;
        logic cs_d;
        logic sdi_m;
        logic sdi_q;
        logic [15:0] shift;
        logic [4:0] cnt;
        logic [7:0] rd_byte;
        logic sdo;
        logic [1:0] main_rsvd;
        logic [2:0] lock;
        logic in1;
        logic in2;
        logic clr_pulse;
        gate_wdog_s gdw;
        oc_monitor_s ocm;
        chop_cfg_s chop;
        logic [23:0] wd_cnt;
        logic wd_fault;
    } bank_state_s;

endpackage
`default_nettype wire

// >>> halfbridge_driver_config_regs.sv
// Overview of operation
// RULE1: Dead time code bits 7-6, reset 00
// RULE2: Watchdog runs only when enable bit set
// RULE3: Watchdog timeout code bits 4-3, reset 00
// RULE4: Gate current code bits 2-0, reset 111
// RULE5: Sense output clamp bit 7, reset clear
// RULE6: Overcurrent threshold code bits 6-4, reset 111
// RULE7: Bit 1 disables high FET monitor
// RULE8: Bit 0 disables low FET monitor
// RULE9: Chop off time code bits 7-6
// RULE10: Bit 5 disables current regulation
// RULE11: Reference scale code bits 4-3, reset 00
// RULE12: Bit 2 enables sample-and-hold mode
// RULE13: Amplifier gain code bits 1-0, reset 01
// RULE14: Key 110 locks, 011 unlocks other registers
// RULE15: Host programs threshold over serial link
// RULE16: Monitor bits 3-2 read zero, ignore writes
// RULE17: Fields update at frame end, read back
`include "halfbridge_cfg_defines.svh"
`default_nettype none
module halfbridge_driver_config_regs #(
    parameter int unsigned WD_CYC_T0 = `WD_TIME0_MS * 1000 * `SYS_CLK_MHZ,
    parameter int unsigned WD_CYC_T1 = `WD_TIME1_MS * 1000 * `SYS_CLK_MHZ,
    parameter int unsigned WD_CYC_T2 = `WD_TIME2_MS * 1000 * `SYS_CLK_MHZ,
    parameter int unsigned WD_CYC_T3 = `WD_TIME3_MS * 1000 * `SYS_CLK_MHZ
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    output halfbridge_cfg_pkg::gate_wdog_s gate_cfg,
    output halfbridge_cfg_pkg::oc_monitor_s monitor_cfg,
    output halfbridge_cfg_pkg::chop_cfg_s chop_cfg,
    output logic lock_active,
    output logic in1_request,
    output logic in2_request,
    output logic clr_fault_pulse,
    output logic wdog_fault
);
    import halfbridge_cfg_pkg::*;

    bank_state_s s_ff;
    bank_state_s nxt_s;
    logic sck_fall;
    logic sck_rise;
    logic cs_fall;
    logic cs_rise;
    logic frame_ok;
    logic wr_commit;
    logic locked;
    logic [3:0] wr_addr;
    logic [7:0] wr_data;
    logic [3:0] rd_addr;
    logic [23:0] wd_limit;

    // Read data for an address; unmapped offsets read zero
    function automatic logic [7:0] read_mux(input bank_state_s st, input logic [3:0] a);
        logic [7:0] r;
        r = 8'h00;
        case (a)
            `ADDR_FAULT_STAT: r = {st.wd_fault, st.wd_fault, 6'h00};
            `ADDR_MAIN_CTRL: r = {st.main_rsvd, st.lock, st.in1, st.in2, 1'b0};
            `ADDR_GATE_WDOG: r = st.gdw;
            `ADDR_OC_MONITOR: r = st.ocm & `OC_MONITOR_WMASK; // RULE16
            `ADDR_CHOP_CFG: r = st.chop;
            default: r = 8'h00;
        endcase
        return r;
    endfunction

    // Edges of the synchronised link signals, taken past the first stage
    assign sck_fall = s_ff.sck_d & ~s_ff.sck_q;
    assign sck_rise = ~s_ff.sck_d & s_ff.sck_q;
    assign cs_fall = s_ff.cs_d & ~s_ff.cs_q;
    assign cs_rise = ~s_ff.cs_d & s_ff.cs_q;
    assign frame_ok = cs_rise && (s_ff.cnt == `FRAME_BITS);
    assign wr_commit = frame_ok && !s_ff.shift[`FRAME_RD_BIT];
    assign wr_addr = s_ff.shift[`FRAME_ADDR_MSB:`FRAME_ADDR_LSB];
    assign wr_data = s_ff.shift[7:0];
    assign rd_addr = {s_ff.shift[2:0], s_ff.sdi_q};
    assign locked = (s_ff.lock == `LOCK_KEY_SET);

    // Timeout length for the selected code
    always_comb begin
        unique case (s_ff.gdw.wdog_timeout_sel)
            2'h0: wd_limit = 24'(WD_CYC_T0); // RULE3
            2'h1: wd_limit = 24'(WD_CYC_T1);
            2'h2: wd_limit = 24'(WD_CYC_T2);
            2'h3: wd_limit = 24'(WD_CYC_T3);
        endcase
    end

    // Next state of the whole bank
    always_comb begin
        nxt_s = s_ff;
        nxt_s.sck_m = spi_sclk;
        nxt_s.sck_q = s_ff.sck_m;
        nxt_s.sck_d = s_ff.sck_q;
        nxt_s.cs_m = spi_cs_n;
        nxt_s.cs_q = s_ff.cs_m;
        nxt_s.cs_d = s_ff.cs_q;
        nxt_s.sdi_m = spi_sdi;
        nxt_s.sdi_q = s_ff.sdi_m;
        nxt_s.clr_pulse = 1'b0;
        // Shift engine: sample on falling clock, drive on rising clock
        if (cs_fall) begin
            nxt_s.cnt = 5'h00;
            nxt_s.sdo = 1'b0;
        end else if (!s_ff.cs_q) begin
            // Count past 16 so an over-long frame is seen and dropped at deselect
            if (sck_fall && s_ff.cnt != 5'h1F) begin
                nxt_s.shift = {s_ff.shift[14:0], s_ff.sdi_q};
                nxt_s.cnt = s_ff.cnt + 5'h01;
                if (s_ff.cnt == `FRAME_ADDR_DONE) begin
                    nxt_s.rd_byte = read_mux(s_ff, rd_addr); // RULE17
                end
            end
            if (sck_rise) begin
                if (s_ff.cnt >= `FRAME_DATA_BITS && s_ff.cnt < `FRAME_BITS) begin
                    nxt_s.sdo = s_ff.rd_byte[3'(5'h0F - s_ff.cnt)];
                end else begin
                    nxt_s.sdo = 1'b0;
                end
            end
        end
        // Commit only complete frames, so a torn frame changes nothing
        if (wr_commit) begin
            case (wr_addr)
                `ADDR_MAIN_CTRL: begin
                    nxt_s.main_rsvd = wr_data[7:6];
                    nxt_s.in1 = wr_data[`IN1_BIT];
                    nxt_s.in2 = wr_data[`IN2_BIT];
                    nxt_s.clr_pulse = wr_data[`CLR_FAULT_BIT];
                    if (!locked && wr_data[`LOCK_MSB:`LOCK_LSB] == `LOCK_KEY_SET) begin
                        nxt_s.lock = `LOCK_KEY_SET; // RULE14
                    end else if (locked && wr_data[`LOCK_MSB:`LOCK_LSB] == `LOCK_KEY_CLEAR) begin
                        nxt_s.lock = `LOCK_KEY_CLEAR; // RULE14
                    end
                    if (wr_data[`CLR_FAULT_BIT]) begin
                        nxt_s.wd_fault = 1'b0;
                    end
                end
                `ADDR_GATE_WDOG: begin
                    if (!locked) begin
                        nxt_s.gdw = gate_wdog_s'(wr_data); // RULE1 RULE2 RULE3 RULE4 RULE17
                    end
                end
                `ADDR_OC_MONITOR: begin
                    if (!locked) begin
                        nxt_s.ocm = oc_monitor_s'(wr_data & `OC_MONITOR_WMASK); // RULE5 RULE6 RULE7 RULE8 RULE16
                    end
                end
                `ADDR_CHOP_CFG: begin
                    if (!locked) begin
                        nxt_s.chop = chop_cfg_s'(wr_data); // RULE9 RULE10 RULE11 RULE12 RULE13
                    end
                end
                default: begin
                end
            endcase
        end
        // Watchdog: any good frame restarts it, so expiry never lands in the same cycle as a clear
        if (!s_ff.gdw.wdog_enable) begin
            nxt_s.wd_cnt = 24'h000000; // RULE2
        end else if (frame_ok) begin
            nxt_s.wd_cnt = 24'h000000;
        end else if (s_ff.wd_cnt >= wd_limit - 24'h000001) begin
            nxt_s.wd_cnt = 24'h000000;
            nxt_s.wd_fault = 1'b1; // RULE3
        end else begin
            nxt_s.wd_cnt = s_ff.wd_cnt + 24'h000001;
        end
    end

    // State register; link lines idle high except clock and data
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_ff <= '0;
            s_ff.cs_m <= 1'b1;
            s_ff.cs_q <= 1'b1;
            s_ff.cs_d <= 1'b1;
            {s_ff.main_rsvd, s_ff.lock, s_ff.in1, s_ff.in2} <= 7'(`MAIN_CTRL_RST >> 1);
            s_ff.gdw <= `GATE_WDOG_RST; // RULE1 RULE2 RULE3 RULE4
            s_ff.ocm <= `OC_MONITOR_RST; // RULE5 RULE6 RULE7 RULE8
            s_ff.chop <= `CHOP_CFG_RST; // RULE9 RULE10 RULE11 RULE12 RULE13
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Outputs straight from the state register
    assign spi_sdo = s_ff.sdo;
    assign spi_sdo_oe = ~s_ff.cs_q;
    assign gate_cfg = s_ff.gdw;
    assign monitor_cfg = s_ff.ocm;
    assign chop_cfg = s_ff.chop;
    assign lock_active = locked;
    assign in1_request = s_ff.in1;
    assign in2_request = s_ff.in2;
    assign clr_fault_pulse = s_ff.clr_pulse;
    assign wdog_fault = s_ff.wd_fault;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    a_reset_values: assert property ($rose(reset_n) |-> gate_cfg == `GATE_WDOG_RST && chop_cfg == `CHOP_CFG_RST
        && monitor_cfg == `OC_MONITOR_RST) else $error("control fields not at reset values"); // RULE1
    a_gate_write_lands: assert property (wr_commit && !locked && wr_addr == `ADDR_GATE_WDOG
        |=> gate_cfg == $past(wr_data)) else $error("gate register write lost"); // RULE17
    a_chop_write_lands: assert property (wr_commit && !locked && wr_addr == `ADDR_CHOP_CFG
        |=> chop_cfg == $past(wr_data)) else $error("chop register write lost"); // RULE9
    a_monitor_write_masked: assert property (wr_commit && !locked && wr_addr == `ADDR_OC_MONITOR
        |=> monitor_cfg == ($past(wr_data) & `OC_MONITOR_WMASK)) else $error("monitor write wrong"); // RULE6
    a_monitor_rsvd_zero: assert property (monitor_cfg.reserved == 2'h0)
        else $error("monitor reserved bits not zero"); // RULE16
    a_lock_blocks_write: assert property (locked && wr_commit && wr_addr != `ADDR_MAIN_CTRL
        |=> $stable(gate_cfg) && $stable(monitor_cfg) && $stable(chop_cfg))
        else $error("write accepted while locked"); // RULE14
    a_lock_key_unlock: assert property (locked && wr_commit && wr_addr == `ADDR_MAIN_CTRL
        && wr_data[`LOCK_MSB:`LOCK_LSB] == `LOCK_KEY_CLEAR |=> !lock_active)
        else $error("unlock key ignored"); // RULE14
    a_lock_other_key: assert property (wr_commit && wr_addr == `ADDR_MAIN_CTRL
        && wr_data[`LOCK_MSB:`LOCK_LSB] != `LOCK_KEY_SET && wr_data[`LOCK_MSB:`LOCK_LSB] != `LOCK_KEY_CLEAR
        |=> $stable(lock_active)) else $error("stray key changed lock"); // RULE14
    a_wdog_needs_enable: assert property ($rose(wdog_fault) |-> $past(gate_cfg.wdog_enable))
        else $error("watchdog fired while disabled"); // RULE2
    a_wdog_count_bound: assert property (gate_cfg.wdog_enable && s_ff.wd_cnt >= wd_limit - 24'h000001
        && !frame_ok |=> wdog_fault && s_ff.wd_cnt == 24'h000000) else $error("watchdog period wrong"); // RULE3
    a_sdo_idle_off: assert property (!s_ff.cs_q && !cs_fall && s_ff.cnt < `FRAME_DATA_BITS |-> !spi_sdo)
        else $error("output high before data phase"); // RULE17

    c_write_frame: cover property (wr_commit);
    c_read_frame: cover property (frame_ok && s_ff.shift[`FRAME_RD_BIT]);
    c_lock_engaged: cover property ($rose(lock_active));
    c_wdog_expired: cover property ($rose(wdog_fault));
endmodule
`default_nettype wire

// >>> spi_host_model.sv
`default_nettype none
module spi_host_model (
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_sdi,
    input wire logic spi_sdo
);
    timeunit 1ns;
    timeprecision 100ps;

    // Half of the 125 ns link period, unrelated to the system clock
    localparam realtime HALF = 62.5;

    // Link idles with the clock low and the frame deselected
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_sdi = 1'b0;
    end

    // One frame, MSB first; an edge count other than 16 gives a frame the device must drop
    task automatic xfer(input logic [15:0] tx, input int nedges, output logic [15:0] rx);
        logic [31:0] bits;
        bits = {tx, tx};
        rx = 16'h0000;
        spi_cs_n = 1'b0;
        #(HALF);
        for (int i = 0; i < nedges; i++) begin
            spi_sclk = 1'b1;
            spi_sdi = bits[31 - i];
            #(HALF);
            spi_sclk = 1'b0;
            rx = {rx[14:0], spi_sdo};
            #(HALF);
        end
        spi_cs_n = 1'b1;
        // Deselected data line shows the inverse, never a stale copy
        spi_sdi = ~spi_sdi;
        #100;
    endtask
endmodule
`default_nettype wire

// >>> tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import halfbridge_cfg_pkg::*;

    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    wire spi_sclk;
    wire spi_cs_n;
    wire spi_sdi;
    logic spi_sdo, spi_sdo_oe, lock_active, in1_request, in2_request, clr_fault_pulse, wdog_fault;
    gate_wdog_s gate_cfg;
    oc_monitor_s monitor_cfg;
    chop_cfg_s chop_cfg;
    int errors = 0;
    int n_tests = 0;
    logic [15:0] rx;
    logic clr_seen = 1'b0;
    logic [7:0] pats [4] = '{8'h00, 8'hFF, 8'hA5, 8'h5A};

    always #5 sys_clk = ~sys_clk;

    // Short watchdog counts keep the run brief
    halfbridge_driver_config_regs #(.WD_CYC_T0(50), .WD_CYC_T1(100), .WD_CYC_T2(200), .WD_CYC_T3(400)) uut (
        .sys_clk(sys_clk), .reset_n(reset_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
        .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .gate_cfg(gate_cfg), .monitor_cfg(monitor_cfg),
        .chop_cfg(chop_cfg), .lock_active(lock_active), .in1_request(in1_request), .in2_request(in2_request),
        .clr_fault_pulse(clr_fault_pulse), .wdog_fault(wdog_fault));

    spi_host_model host (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo));

    // Pulse is one cycle long, so catch it as it passes
    always @(posedge sys_clk) begin
        if (clr_fault_pulse === 1'b1) clr_seen <= 1'b1;
    end

    task automatic report_and_stop();
        if (errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] addr, input logic [7:0] data);
        host.xfer({1'b0, addr, 3'b000, data}, 16, rx);
    endtask

    // Read back and compare; upper byte of the answer is always zero
    task automatic rdchk(input logic [3:0] addr, input logic [7:0] exp);
        host.xfer({1'b1, addr, 3'b000, 8'h00}, 16, rx);
        check(rx, {8'h00, exp}, "read back");
    endtask

    // Both the output port and the serial read must agree
    task automatic cfg_check(input logic [3:0] addr, input logic [7:0] exp);
        logic [7:0] port;
        port = (addr == 4'h3) ? gate_cfg : (addr == 4'h4) ? monitor_cfg : chop_cfg;
        check({8'h00, port}, {8'h00, exp}, "config port");
        rdchk(addr, exp);
    endtask

    task automatic t_reset();
        check({15'h0, spi_sdo_oe}, 16'h0000, "sdo enable idle");
        cfg_check(4'h3, 8'h07);
        cfg_check(4'h4, 8'h70);
        cfg_check(4'h5, 8'h01);
        check({15'h0, lock_active}, 16'h0000, "lock after reset");
    endtask

    // Every pattern to registers 3 to 5; reserved monitor bits stay zero
    task automatic t_fields();
        for (int p = 0; p < 4; p++) begin
            for (int a = 3; a <= 5; a++) begin
                wr(a[3:0], pats[p]);
                cfg_check(a[3:0], (a == 4) ? (pats[p] & 8'hF3) : pats[p]);
            end
        end
    endtask

    task automatic t_lock();
        wr(4'h2, 8'h28);
        rdchk(4'h2, 8'h18);
        wr(4'h2, 8'h30);
        check({15'h0, lock_active}, 16'h0001, "lock set");
        wr(4'h3, 8'h00);
        cfg_check(4'h3, 8'h5A);
        wr(4'h2, 8'h28);
        check({15'h0, lock_active}, 16'h0001, "wrong key");
        wr(4'h2, 8'h18);
        check({15'h0, lock_active}, 16'h0000, "unlock");
        wr(4'h3, 8'h00);
        cfg_check(4'h3, 8'h00);
        wr(4'h2, 8'h1E);
        check({14'h0, in1_request, in2_request}, 16'h0003, "input requests");
        wr(4'h2, 8'h18);
        check({14'h0, in1_request, in2_request}, 16'h0000, "input requests off");
    endtask

    // Short and long frames are dropped; unmapped places read zero
    task automatic t_frames();
        host.xfer({1'b0, 4'h5, 3'b000, 8'hFF}, 15, rx);
        cfg_check(4'h5, 8'h5A);
        host.xfer({1'b0, 4'h5, 3'b000, 8'hFF}, 17, rx);
        cfg_check(4'h5, 8'h5A);
        wr(4'h7, 8'hFF);
        rdchk(4'h7, 8'h00);
    endtask

    task automatic t_wdog();
        int n;
        // Earlier patterns enabled a short timeout, so start from a cleared fault
        wr(4'h2, 8'h19);
        repeat (500) @(posedge sys_clk);
        check({15'h0, wdog_fault}, 16'h0000, "watchdog off");
        wr(4'h3, 8'h38);
        for (n = 0; n < 600 && wdog_fault !== 1'b1; n++) @(posedge sys_clk);
        if (n >= 600) begin
            errors++;
            report_and_stop();
        end
        check({15'h0, (n >= 380 && n <= 400)}, 16'h0001, "watchdog period");
        clr_seen = 1'b0;
        wr(4'h2, 8'h19);
        check({14'h0, clr_seen, wdog_fault}, 16'h0002, "fault clear");
        wr(4'h3, 8'h18);
    endtask

    // Hang guard
    initial begin
        #1ms;
        errors++;
        report_and_stop();
    end

    initial begin
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        t_reset();
        t_fields();
        t_lock();
        t_frames();
        t_wdog();
        report_and_stop();
    end
endmodule
`default_nettype wire
